// ---- rtl/fiso_defs.vh ----
// Purpose: constants for the flash identification, suspend and security register command block
// Assumes: single SPI mode, opcode first, MSB first on the serial link
// Notes:
// Overview of operation
// [R1] opcode 90H plus address 000000H returns manufacturer then device byte, MSB first
// [R2] opcode 9FH returns manufacturer code, memory type, capacity: 24 bits on falling edges
// [R3] identification read during a running erase or program is not decoded; code ignores only 9FH when busy, 90H and 4BH still answer
// [R4] host should not send identification read in deep power-down
// [R5] chip select high ends identification output; device waits for next selection
// [R6] opcode 4BH, address, dummy byte, then 128-bit unique number until deselect
// [R7] suspend 75H accepted only during array program/erase, busy set, suspend clear
// [R8] accepted suspend sets suspend flag at once, halts operation, clears busy
// [R9] program suspended refuses status writes, security erase/program, erases, page programs
// [R10] erase suspended refuses status writes, security erase and all erases
// [R11] resume 7AH accepted only with suspend flag set and busy clear
// [R12] accepted resume clears suspend flag now, busy back within 200ns
// [R13] three independent 1024-byte security registers
// [R14] address A23-16 zero, A11-10 zero, A15-12 selects register one to three
// [R15] security erase 44H needs write latch, deselect exactly after last address bit
// [R16] security program 42H, address, data bytes; cycle starts at deselect
// [R17] busy during security cycle, write latch cleared before cycle end
// [R18] lock bit set makes security erase and program ignored forever
// [R19] security read 48H, address, dummy byte, then data on falling edges
// [R20] read offset increments per byte, wraps 3FFH to 000H inside the register
// [R21] refused or ignored commands change no flags, latch or memory
// [R22] erase and program need write latch set beforehand
`ifndef FISO_DEFS_VH
`define FISO_DEFS_VH
`define OP_MFR_DEV_ID   8'h90
`define OP_JEDEC_ID     8'h9f
`define OP_UNIQUE_ID    8'h4b
`define OP_SUSPEND      8'h75
`define OP_RESUME       8'h7a
`define OP_OTP_ERASE    8'h44
`define OP_OTP_PROG     8'h42
`define OP_OTP_READ     8'h48
`define OP_WRSR1        8'h01
`define OP_WRSR2        8'h31
`define OP_WRSR3        8'h11
`define OP_SECT_ERASE   8'h20
`define OP_BLK32_ERASE  8'h52
`define OP_BLK64_ERASE  8'hd8
`define OP_CHIP_ERASE1  8'hc7
`define OP_CHIP_ERASE2  8'h60
`define OP_PAGE_PROG    8'h02
`define OP_QPAGE_PROG   8'h32
`define CNT_OP_END      3'd0
`define CNT_ADDR_LAST   3'd3
`define CNT_ADDR_END    3'd4
`define CNT_DATA_FIRST  3'd5
`define CNT_SAT         3'd7
`define BIT_LAST        3'd7
`define ADDR_HI_ZERO    8'h00
`define ADDR_MID_ZERO   2'b00
`define OTP_SEL_ONE     4'h1
`define OTP_SEL_TWO     4'h2
`define OTP_SEL_THREE   4'h3
`define ERASED_BYTE     8'hff
`define JEDEC_IDENT_READ_LAST_IDX   4'h2
`define CLK_MHZ         250
`define RESUME_NS       200
`endif

// ---- rtl/fiso_fifo.v ----
// Purpose: small byte FIFO between the serial receiver and the command decoder
// Assumes: same clock on both sides
// Notes: clr empties it at deselect
`timescale 1ns/10ps
module fiso_fifo #(
  parameter W  = 8,
  parameter D  = 4,
  parameter AW = 2
)(
  input  wire         core_clk,
  input  wire         resetn,
  input  wire         clr,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rp_r];
  function [AW-1:0] nxt;
    input [AW-1:0] p;
    nxt = (p == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
  endfunction
  always @(posedge core_clk) begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_r <= nxt(wp_r);
      if (pop)
        rp_r <= nxt(rp_r);
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // fiso_fifo

// ---- rtl/fiso_core.v ----
// Purpose: identification, suspend/resume and security register commands of a serial NOR flash
// Assumes: cs_n, sclk, si come from the pins; array program/erase sequencer lives outside
// Notes: sclk is oversampled by core_clk, so it must stay at or below about an eighth of core_clk (each phase at least four core cycles)
`include "fiso_defs.vh"
`timescale 1ns/10ps
module fiso_core #(
  parameter [7:0]   MFR_ID     = 8'h5a,  // arbitrary value
  parameter [7:0]   DEV_ID     = 8'h15,  // arbitrary value
  parameter [7:0]   MEM_TYPE   = 8'h40,  // arbitrary value
  parameter [7:0]   MEM_CAP    = 8'h16,  // arbitrary value
  parameter [127:0] UNIQUE_ID  = 128'h0123456789abcdeffedcba9876543210,  // arbitrary value
  parameter         OTP_AW     = 10,
  parameter         ERASE_NS   = 50000,
  parameter         PROG_NS    = 5000,
  parameter         ERASE_CYC  = ERASE_NS * `CLK_MHZ / 1000,
  parameter         PROG_CYC   = PROG_NS * `CLK_MHZ / 1000
)(
  input  wire core_clk,
  input  wire resetn,
  input  wire cs_n,
  input  wire sclk,
  input  wire si,
  output wire so,
  output wire so_oe,
  input  wire array_running,
  input  wire array_is_prog,
  output wire array_halt,
  input  wire write_latch,
  output wire write_latch_clr,
  input  wire otp_lock_one,
  input  wire otp_lock_two,
  input  wire otp_lock_three,
  output wire busy_flag,
  output wire erase_suspended_flag,
  output wire program_suspended_flag,
  output wire cmd_refused,
  output wire rx_fifo_ready
);
  localparam M_IDLE = 2'b00;
  localparam M_OUT  = 2'b01;
  localparam M_IGN  = 2'b10;
  localparam RES_CYC = `RESUME_NS * `CLK_MHZ / 1000;
  localparam MW      = OTP_AW + 2;
  localparam NBYTES  = 3 << OTP_AW;

  // pin synchronisers
  reg cs_m_r, cs_s_r, cs_d_r;
  reg ck_m_r, ck_s_r, ck_d_r;
  reg si_m_r, si_s_r;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      ck_m_r <= 1'b0;
      ck_s_r <= 1'b0;
      ck_d_r <= 1'b0;
      si_m_r <= 1'b0;
      si_s_r <= 1'b0;
    end else begin
      cs_m_r <= cs_n;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      ck_m_r <= sclk;
      ck_s_r <= ck_m_r;
      ck_d_r <= ck_s_r;
      si_m_r <= si;
      si_s_r <= si_m_r;
    end
  end
  wire ck_rise = ck_s_r & ~ck_d_r & ~cs_s_r;
  wire ck_fall = ~ck_s_r & ck_d_r & ~cs_s_r;
  wire cs_rise = cs_s_r & ~cs_d_r;

  // address helpers
  function [1:0] otp_sel;
    input [23:0] a;
    begin
      otp_sel = 2'd0;
      if (a[23:16] == `ADDR_HI_ZERO && a[11:10] == `ADDR_MID_ZERO) begin // R14
        if (a[15:12] == `OTP_SEL_ONE)
          otp_sel = 2'd1;
        else if (a[15:12] == `OTP_SEL_TWO)
          otp_sel = 2'd2;
        else if (a[15:12] == `OTP_SEL_THREE)
          otp_sel = 2'd3;
      end
    end
  endfunction
  function refused;
    input [7:0] op;
    input       psus;
    input       esus;
    case (op)
      `OP_WRSR1, `OP_WRSR2, `OP_WRSR3, `OP_OTP_ERASE, `OP_SECT_ERASE, `OP_BLK32_ERASE,
      `OP_BLK64_ERASE, `OP_CHIP_ERASE1, `OP_CHIP_ERASE2: refused = psus | esus; // R9 R10
      `OP_OTP_PROG, `OP_PAGE_PROG, `OP_QPAGE_PROG:       refused = psus; // R9
      default:                                           refused = 1'b0;
    endcase
  endfunction

  // serial shifter
  reg [6:0] rx_sh_r;
  reg [2:0] bit_r;
  reg [2:0] rx_cnt_r;
  reg [7:0] so_sh_r;
  wire      push_v = ck_rise & (bit_r == `BIT_LAST);
  wire [7:0] push_d = {rx_sh_r, si_s_r};

  wire       f_valid;
  wire [7:0] f_data;
  reg        hold_r;
  wire       dec_ready = ~hold_r;
  wire       pop = f_valid & dec_ready & ~cs_s_r;

  fiso_fifo #(.W(8), .D(4), .AW(2)) u_rx_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .clr       (cs_s_r),
    .in_valid  (push_v),
    .in_ready  (rx_fifo_ready),
    .in_data   (push_d),
    .out_valid (f_valid),
    .out_ready (dec_ready),
    .out_data  (f_data)
  );

  reg  [1:0]  mode_r;
  reg  [2:0]  cnt_r;
  reg  [7:0]  op_r;
  reg  [23:0] addr_r;
  reg  [3:0]  idx_r;
  reg  [1:0]  rsel_r;
  reg  [OTP_AW-1:0] rd_off_r;
  reg  [OTP_AW-1:0] wr_off_r;
  reg  [1:0]  wsel_r;
  reg         prog_ok_r;
  reg  [7:0]  mem_r [0:NBYTES-1];
  wire [23:0] addr_full = {addr_r[15:0], f_data};
  wire [1:0]  sel_full  = otp_sel(addr_full);
  // full address kept: register select needs A23-16 as well as A15-10
  wire [23:0] addr_done = addr_r;
  wire        tx_take   = ck_fall & (bit_r == 3'd0) & (mode_r == M_OUT);

  // byte presented on the next output boundary
  reg [7:0] cur_byte;
  always @* begin
    cur_byte = `ERASED_BYTE;
    case (op_r)
      `OP_MFR_DEV_ID: cur_byte = idx_r[0] ? DEV_ID : MFR_ID; // R1
      `OP_JEDEC_ID: begin // R2
        if (idx_r == 4'h0)
          cur_byte = MFR_ID;
        else if (idx_r == 4'h1)
          cur_byte = MEM_TYPE;
        else
          cur_byte = MEM_CAP;
      end
      `OP_UNIQUE_ID: cur_byte = UNIQUE_ID[8'd127 - {idx_r, 3'b000} -: 8]; // R6
      `OP_OTP_READ: begin
        if (rsel_r != 2'd0)
          cur_byte = mem_r[{rsel_r - 2'd1, rd_off_r}]; // R19
      end
      default: cur_byte = `ERASED_BYTE;
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sh_r  <= 7'h00;
      bit_r    <= 3'd0;
      rx_cnt_r <= 3'd0;
      so_sh_r  <= 8'h00;
    end else if (cs_s_r) begin
      bit_r    <= 3'd0;
      rx_cnt_r <= 3'd0;
    end else begin
      if (ck_rise) begin
        rx_sh_r <= push_d[6:0];
        bit_r   <= bit_r + 3'd1;
        if (bit_r == `BIT_LAST && rx_cnt_r != `CNT_SAT)
          rx_cnt_r <= rx_cnt_r + 3'd1;
      end
      if (tx_take)
        so_sh_r <= cur_byte;
      else if (ck_fall)
        so_sh_r <= {so_sh_r[6:0], 1'b0};
    end
  end
  assign so    = so_sh_r[7];
  assign so_oe = (mode_r == M_OUT) & ~cs_s_r; // R5

  // suspend state
  reg        halt_r, psus_r, esus_r, res_pend_r;
  reg [7:0]  res_cnt_r;
  reg        otp_busy_r;
  assign busy_flag = otp_busy_r | (array_running & ~halt_r); // R8
  wire sus_acc = pop & (cnt_r == `CNT_OP_END) & (f_data == `OP_SUSPEND) & array_running &
                 ~halt_r & ~psus_r & ~esus_r & ~res_pend_r; // R7
  wire res_acc = pop & (cnt_r == `CNT_OP_END) & (f_data == `OP_RESUME) & (psus_r | esus_r) &
                 ~busy_flag; // R11
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      halt_r     <= 1'b0;
      psus_r     <= 1'b0;
      esus_r     <= 1'b0;
      res_pend_r <= 1'b0;
      res_cnt_r  <= 8'h00;
    end else if (sus_acc) begin
      halt_r <= 1'b1; // R8
      if (array_is_prog)
        psus_r <= 1'b1;
      else
        esus_r <= 1'b1;
    end else if (res_acc) begin
      psus_r     <= 1'b0; // R12
      esus_r     <= 1'b0;
      res_pend_r <= 1'b1;
      res_cnt_r  <= RES_CYC[7:0];
    end else if (res_pend_r) begin
      res_cnt_r <= res_cnt_r - 8'h01;
      if (res_cnt_r == 8'h01) begin
        halt_r     <= 1'b0; // R12
        res_pend_r <= 1'b0;
      end
    end
  end
  assign array_halt             = halt_r;
  assign erase_suspended_flag   = esus_r;
  assign program_suspended_flag = psus_r;
  assign cmd_refused = (cnt_r != `CNT_OP_END) & ~cs_s_r & refused(op_r, psus_r, esus_r);

  function locked;
    input [1:0] s;
    locked = (s == 2'd1 && otp_lock_one) || (s == 2'd2 && otp_lock_two) || (s == 2'd3 && otp_lock_three);
  endfunction

  // decoder
  wire prog_we = pop & (cnt_r >= `CNT_ADDR_END) & (op_r == `OP_OTP_PROG) & prog_ok_r;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r    <= M_IDLE;
      cnt_r     <= 3'd0;
      op_r      <= 8'h00;
      addr_r    <= 24'h000000;
      idx_r     <= 4'h0;
      rsel_r    <= 2'd0;
      rd_off_r  <= {OTP_AW{1'b0}};
      wr_off_r  <= {OTP_AW{1'b0}};
      wsel_r    <= 2'd0;
      prog_ok_r <= 1'b0;
      hold_r    <= 1'b0;
    end else if (cs_s_r) begin
      mode_r <= M_IDLE; // R5
      cnt_r  <= 3'd0;
      idx_r  <= 4'h0;
      hold_r <= 1'b0;
    end else begin
      hold_r <= prog_we;  // write port needs a spare cycle after each byte
      if (pop) begin
        if (cnt_r != `CNT_SAT)
          cnt_r <= cnt_r + 3'd1;
        if (cnt_r == `CNT_OP_END) begin
          op_r      <= f_data;
          prog_ok_r <= 1'b0;
          if (f_data == `OP_JEDEC_ID)
            mode_r <= busy_flag ? M_IGN : M_OUT; // R3
        end else if (cnt_r < `CNT_ADDR_END) begin
          addr_r <= addr_full;
        end
        if (cnt_r == `CNT_ADDR_LAST && op_r == `OP_MFR_DEV_ID)
          mode_r <= M_OUT; // R1
        if (cnt_r == `CNT_ADDR_LAST && op_r == `OP_OTP_PROG) begin
          wsel_r    <= sel_full;
          wr_off_r  <= addr_full[OTP_AW-1:0];
          prog_ok_r <= write_latch & (sel_full != 2'd0) & ~locked(sel_full) & ~busy_flag & ~psus_r; // R22 R18 R9
        end
        if (cnt_r == `CNT_ADDR_END && (op_r == `OP_UNIQUE_ID || op_r == `OP_OTP_READ)) begin
          mode_r   <= M_OUT; // R6 R19
          rsel_r   <= otp_sel(addr_done);
          rd_off_r <= addr_r[OTP_AW-1:0];
        end
        if (prog_we)
          wr_off_r <= {wr_off_r[OTP_AW-1:8], wr_off_r[7:0] + 8'h01}; // page wrap
      end
      if (tx_take) begin
        rd_off_r <= rd_off_r + 1'b1; // R20
        if (op_r == `OP_JEDEC_ID && idx_r == `JEDEC_IDENT_READ_LAST_IDX)
          idx_r <= 4'h0;
        else
          idx_r <= idx_r + 4'h1;
      end
    end
  end

  // self-timed security register cycles
  reg [31:0]   tmr_r;
  reg          sweep_r;
  reg [MW-1:0] sweep_idx_r;
  reg          wl_clr_r;
  wire [1:0] esel = otp_sel(addr_done);
  wire start_erase = cs_rise & (op_r == `OP_OTP_ERASE) & (rx_cnt_r == `CNT_ADDR_END) & (bit_r == 3'd0) &
                     write_latch & (esel != 2'd0) & ~locked(esel) & ~busy_flag & ~psus_r & ~esus_r; // R15 R18 R22 R10
  wire start_prog  = cs_rise & (op_r == `OP_OTP_PROG) & prog_ok_r & (rx_cnt_r >= `CNT_DATA_FIRST); // R16
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      otp_busy_r  <= 1'b0;
      tmr_r       <= 32'h0;
      sweep_r     <= 1'b0;
      sweep_idx_r <= {MW{1'b0}};
      wl_clr_r    <= 1'b0;
    end else begin
      wl_clr_r <= 1'b0;
      if (start_erase) begin
        otp_busy_r  <= 1'b1; // R17
        tmr_r       <= ERASE_CYC[31:0];
        sweep_r     <= 1'b1;
        sweep_idx_r <= {esel - 2'd1, {OTP_AW{1'b0}}}; // R13
        wl_clr_r    <= 1'b1; // R17
      end else if (start_prog) begin
        otp_busy_r <= 1'b1; // R17
        tmr_r      <= PROG_CYC[31:0];
        wl_clr_r   <= 1'b1; // R17
      end else if (otp_busy_r) begin
        if (sweep_r) begin
          sweep_idx_r <= sweep_idx_r + 1'b1;
          if (&sweep_idx_r[OTP_AW-1:0])
            sweep_r <= 1'b0;
        end
        if (tmr_r != 32'h0)
          tmr_r <= tmr_r - 32'h1;
        else if (!sweep_r)
          otp_busy_r <= 1'b0; // R17
      end
    end
  end
  assign write_latch_clr = wl_clr_r;

  // nonvolatile storage: no reset, contents survive
  always @(posedge core_clk) begin
    if (sweep_r)
      mem_r[sweep_idx_r] <= `ERASED_BYTE;
    else if (prog_we)
      mem_r[{wsel_r - 2'd1, wr_off_r}] <= mem_r[{wsel_r - 2'd1, wr_off_r}] & f_data; // R21
  end
endmodule // fiso_core

// ---- verif/fiso_core_sva.sv ----
// Purpose: concurrent checks on the ports of fiso_core
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every fiso_core instance
`timescale 1ns/10ps
module fiso_core_sva (
  input wire core_clk,
  input wire resetn,
  input wire cs_n,
  input wire so_oe,
  input wire array_running,
  input wire array_is_prog,
  input wire array_halt,
  input wire write_latch,
  input wire write_latch_clr,
  input wire busy_flag,
  input wire erase_suspended_flag,
  input wire program_suspended_flag,
  input wire cmd_refused
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sus_excl_a: assert property (!(erase_suspended_flag && program_suspended_flag))
    else $error("both suspend flags set");
  psus_cond_a: assert property ($rose(program_suspended_flag) |-> $past(busy_flag) && $past(array_is_prog))
    else $error("program suspend taken without running program");
  esus_cond_a: assert property ($rose(erase_suspended_flag) |-> $past(busy_flag) && !$past(array_is_prog))
    else $error("erase suspend taken without running erase");
  sus_halt_a: assert property ($rose(erase_suspended_flag || program_suspended_flag) |-> array_halt ##1 !busy_flag)
    else $error("suspend did not halt and drop busy");
  res_cond_a: assert property ($fell(erase_suspended_flag || program_suspended_flag) |-> !$past(busy_flag))
    else $error("resume taken while busy");
  res_busy_a: assert property ($fell(erase_suspended_flag || program_suspended_flag) && array_running
                               |-> ##[1:51] busy_flag)
    else $error("busy not back after resume");
  run_busy_a: assert property (array_running && !array_halt |-> busy_flag)
    else $error("running array not shown busy");
  oe_desel_a: assert property (cs_n [*4] |-> !so_oe)
    else $error("output still enabled after deselect");
  latch_clr_a: assert property (write_latch_clr |-> busy_flag && $past(write_latch))
    else $error("latch clear outside a security cycle");
  refuse_a: assert property (cmd_refused |-> (erase_suspended_flag || program_suspended_flag) &&
                             $stable(erase_suspended_flag) && $stable(program_suspended_flag) &&
                             !write_latch_clr)
    else $error("refused command changed state or had no suspend");
endmodule // fiso_core_sva

bind fiso_core fiso_core_sva fiso_core_sva_i (
  .core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .so_oe(so_oe), .array_running(array_running),
  .array_is_prog(array_is_prog), .array_halt(array_halt), .write_latch(write_latch),
  .write_latch_clr(write_latch_clr), .busy_flag(busy_flag), .erase_suspended_flag(erase_suspended_flag),
  .program_suspended_flag(program_suspended_flag), .cmd_refused(cmd_refused));

// ---- verif/fiso_host_model.sv ----
// Purpose: host serial flash controller driving chip select, clock and data in
// Assumes: mode 0, clock idles low and stands still between frames
// Notes: half clock period is 8 core cycles, 64 ns per bit
`timescale 1ns/10ps
module fiso_host_model (
  input  wire core_clk,
  input  wire so,
  output reg  cs_n,
  output reg  sclk,
  output reg  si
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // never sends power-down, so identification reads are always legal
  task sel;
    begin
      cs_n <= 1'b0;
      tick(8);
    end
  endtask
  // data in is not held after deselect: show the inverse level
  task desel;
    begin
      tick(8);
      cs_n <= 1'b1;
      si   <= ~si;
      tick(8);
    end
  endtask
  // bits go out MSB first; data out is taken at the rising clock
  task xfer(input [7:0] b, output [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        si <= b[i];
        tick(8);
        sclk <= 1'b1;
        r[i] = so;
        tick(8);
        sclk <= 1'b0;
      end
    end
  endtask
endmodule // fiso_host_model

// ---- verif/tb.sv ----
// Purpose: self-checking bench for fiso_core
// Assumes: host model drives the serial pins, bench drives the status inputs
// Notes: erase cycle shortened to 1100 core cycles
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks = num_checks + 1; if ((a) !== (e)) begin err_count = err_count + 1; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
  localparam [7:0]   MFR = 8'hc3;  // arbitrary value
  localparam [7:0]   DEV = 8'h2e;  // arbitrary value
  localparam [7:0]   TYP = 8'h71;  // arbitrary value
  localparam [7:0]   CAP = 8'h1b;  // arbitrary value
  localparam [127:0] UID = 128'h00112233445566778899aabbccddeeff;  // arbitrary value
  reg     core_clk, resetn, array_running, array_is_prog, write_latch;
  reg     otp_lock_one, otp_lock_two, otp_lock_three;
  wire    cs_n, sclk, si, so, so_oe, array_halt, write_latch_clr, busy_flag;
  wire    erase_suspended_flag, program_suspended_flag, cmd_refused, rx_fifo_ready;
  integer err_count, num_checks;
  reg [7:0] rd;

  fiso_core #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(TYP), .MEM_CAP(CAP), .UNIQUE_ID(UID),
    .ERASE_CYC(1100), .PROG_CYC(20)) fiso_core_i (
    .core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
    .array_running(array_running), .array_is_prog(array_is_prog), .array_halt(array_halt),
    .write_latch(write_latch), .write_latch_clr(write_latch_clr), .otp_lock_one(otp_lock_one),
    .otp_lock_two(otp_lock_two), .otp_lock_three(otp_lock_three), .busy_flag(busy_flag),
    .erase_suspended_flag(erase_suspended_flag), .program_suspended_flag(program_suspended_flag),
    .cmd_refused(cmd_refused), .rx_fifo_ready(rx_fifo_ready));
  fiso_host_model fiso_host_model_i (.core_clk(core_clk), .so(so), .cs_n(cs_n), .sclk(sclk), .si(si));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // shared latch: the pulse clears it
  always @(posedge core_clk) if (write_latch_clr) write_latch <= 1'b0;

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task put(input [7:0] b);
    fiso_host_model_i.xfer(b, rd);
  endtask
  task get;
    fiso_host_model_i.xfer(8'hff, rd);
  endtask
  task cmd(input [7:0] op);
    begin
      fiso_host_model_i.sel;
      put(op);
    end
  endtask
  task addr(input [23:0] a);
    begin
      put(a[23:16]);
      put(a[15:8]);
      put(a[7:0]);
    end
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      while (busy_flag !== 1'b0 && n < 3000) begin
        tick(1);
        n = n + 1;
      end
      if (n >= 3000) begin
        err_count = err_count + 1;
        tally_and_finish;
      end
    end
  endtask

  task t_ident;
    integer k;
    begin
      cmd(8'h9f);
      get; `CHK(rd, MFR)
      get; `CHK(rd, TYP)
      get; `CHK(rd, CAP)
      `CHK(so_oe, 1'b1)
      fiso_host_model_i.desel;
      `CHK(so_oe, 1'b0)
      `CHK(rx_fifo_ready, 1'b1)
      cmd(8'h90);
      addr(24'h000000);
      get; `CHK(rd, MFR)
      get; `CHK(rd, DEV)
      fiso_host_model_i.desel;
      cmd(8'h4b);
      addr(24'h000000);
      put(8'h00);
      for (k = 0; k < 16; k = k + 1) begin
        get; `CHK(rd, UID[127-8*k -: 8])
      end
      fiso_host_model_i.desel;
      $display("test ident done");
    end
  endtask

  task t_otp;
    begin
      write_latch <= 1'b1;
      cmd(8'h44); addr(24'h001000); fiso_host_model_i.desel;
      `CHK(busy_flag, 1'b1)
      wait_idle;
      `CHK(write_latch, 1'b0)
      write_latch <= 1'b1;
      cmd(8'h42); addr(24'h0013fe); put(8'ha5); put(8'h3c); fiso_host_model_i.desel;
      `CHK(busy_flag, 1'b1)
      wait_idle;
      write_latch <= 1'b1;
      cmd(8'h44); addr(24'h002000); fiso_host_model_i.desel;
      wait_idle;
      cmd(8'h48); addr(24'h0013fe); put(8'h00);
      get; `CHK(rd, 8'ha5)
      get; `CHK(rd, 8'h3c)
      get; `CHK(rd, 8'hff)
      fiso_host_model_i.desel;
      cmd(8'h48); addr(24'h0017fe); put(8'h00);
      get; `CHK(rd, 8'hff)
      fiso_host_model_i.desel;
      $display("test otp done");
    end
  endtask

  task t_ignore;
    begin
      otp_lock_one <= 1'b1;
      write_latch <= 1'b1;
      cmd(8'h44); addr(24'h001000); fiso_host_model_i.desel;
      `CHK(busy_flag, 1'b0)
      `CHK(write_latch, 1'b1)
      otp_lock_one <= 1'b0;
      write_latch <= 1'b0;
      cmd(8'h44); addr(24'h003000); fiso_host_model_i.desel;
      `CHK(busy_flag, 1'b0)
      write_latch <= 1'b1;
      cmd(8'h44); addr(24'h003000); put(8'h00); fiso_host_model_i.desel;
      `CHK(busy_flag, 1'b0)
      $display("test ignore done");
    end
  endtask

  task t_suspend;
    begin
      array_running <= 1'b1;
      array_is_prog <= 1'b1;
      cmd(8'h9f); get; `CHK(so_oe, 1'b0)
      fiso_host_model_i.desel;
      cmd(8'h75); fiso_host_model_i.desel;
      `CHK(program_suspended_flag, 1'b1)
      `CHK(busy_flag, 1'b0)
      `CHK(array_halt, 1'b1)
      cmd(8'h42); tick(8); `CHK(cmd_refused, 1'b1)
      fiso_host_model_i.desel;
      cmd(8'h7a); fiso_host_model_i.desel;
      `CHK(program_suspended_flag, 1'b0)
      tick(40); `CHK(busy_flag, 1'b1)
      array_is_prog <= 1'b0;
      cmd(8'h75); fiso_host_model_i.desel;
      `CHK(erase_suspended_flag, 1'b1)
      cmd(8'h44); tick(8); `CHK(cmd_refused, 1'b1)
      fiso_host_model_i.desel;
      cmd(8'h42); tick(8); `CHK(cmd_refused, 1'b0)
      fiso_host_model_i.desel;
      cmd(8'h7a); fiso_host_model_i.desel;
      tick(60);
      array_running <= 1'b0;
      cmd(8'h75); fiso_host_model_i.desel;
      `CHK({erase_suspended_flag, program_suspended_flag}, 2'b00)
      $display("test suspend done");
    end
  endtask

  initial begin
    err_count = 0;
    num_checks = 0;
    resetn = 1'b0;
    array_running = 1'b0;
    array_is_prog = 1'b0;
    write_latch = 1'b0;
    otp_lock_one = 1'b0;
    otp_lock_two = 1'b0;
    otp_lock_three = 1'b0;
    tick(16);
    resetn <= 1'b1;
    tick(2);
    t_ident;
    t_otp;
    t_ignore;
    t_suspend;
    tally_and_finish;
  end
endmodule // tb
